/* File: atrs_consts.vh */
// Purpose: Constants for the asynchronous timer register transfer block.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes: Register offsets are local choices; field positions follow the status register.
// Overview of operation
// - Async writes land after two oscillator edges
// - Five independent holding registers
// - Compare match suppressed while count/compare pending
// - Interrupt logic rearms after one oscillator cycle
// - Oscillator runs in async mode with external clock off, except power-down and standby
// - Wake starts on next timer clock
// - Count read copy resynced each oscillator edge
// - Flag sync takes three cycles plus timer cycle
// - Compare outputs change on timer clock
// - External clock enable gates crystal and buffer
// - Async select picks oscillator or I/O clock
// - Async write sets busy flag, update clears
// - Async count reads resynced copy, others read holding
`ifndef ATRS_CONSTS_VH
`define ATRS_CONSTS_VH
`define ATRS_OFF_STATUS 12'h000
`define ATRS_OFF_COUNT 12'h004
`define ATRS_OFF_CMP_A 12'h008
`define ATRS_OFF_CMP_B 12'h00c
`define ATRS_OFF_CTRL_A 12'h010
`define ATRS_OFF_CTRL_B 12'h014
`define ATRS_OFF_FLAGS 12'h018
`define ATRS_OFF_SLEEP 12'h01c
`define ATRS_BIT_EXT_CLK 6
`define ATRS_BIT_ASYNC 5
`define ATRS_BIT_CNT_UB 4
`define ATRS_BIT_CMPA_UB 3
`define ATRS_BIT_CMPB_UB 2
`define ATRS_BIT_CTLA_UB 1
`define ATRS_BIT_CTLB_UB 0
`define ATRS_STATUS_RST 8'h00
`define ATRS_REG_RST 8'h00
`define ATRS_XFER_EDGES 2
`define ATRS_FLAG_SYNC_CYC 3
`define ATRS_WAKE_HALT_CYC 3'h4
`define ATRS_SLEEP_PSAVE 3'h3
`define ATRS_SLEEP_NOISE 3'h1
`define ATRS_SLEEP_PDOWN 3'h2
`define ATRS_SLEEP_STBY 3'h6
`endif

/* File: atrs_hold_slot.v */
// Purpose: One holding register with its transfer into the timer domain.
// Assumes: tick is a one-cycle pulse per rising oscillator edge.
// Notes: Instantiated once per asynchronously updated register.
`include "atrs_consts.vh"
module atrs_hold_slot #(
    parameter W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire wr,
    input wire async_mode,
    input wire tick,
    input wire [W-1:0] wdata,
    output reg [W-1:0] hold_ff,
    output wire busy,
    output wire load
);
    reg [1:0] edges_ff;
    reg pend_ff;
    // The value is copied once the second oscillator edge is seen.
    assign load = pend_ff && tick && (edges_ff == 2'd1);
    assign busy = pend_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= `ATRS_REG_RST;
            edges_ff <= 2'd0;
            pend_ff <= 1'b0;
        end else if (wr) begin
            hold_ff <= wdata;
            edges_ff <= 2'd0;
            pend_ff <= async_mode;
        end else if (!async_mode) begin
            pend_ff <= 1'b0;
        end else if (load) begin
            pend_ff <= 1'b0;
        end else if (pend_ff && tick) begin
            edges_ff <= edges_ff + 2'd1;
        end
    end
endmodule // atrs_hold_slot

/* File: atrs_top.v */
// Purpose: Asynchronous timer clocking and register transfer behind an APB slave.
// Assumes: timer_osc_in_pin is sampled at pclk; pclk exceeds four times its rate.
// Notes: Counter modes and prescaler are outside; the counter simply increments.
`include "atrs_consts.vh"
module atrs_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire timer_osc_in_pin,
    output wire osc_enable,
    output wire ext_clk_buf_en,
    output reg cmp_a_out_ff,
    output reg cmp_b_out_ff,
    output wire irq_wake,
    output reg cpu_halt_ff
);
    reg [7:0] status_ff;
    reg [7:0] count_ff;
    reg [7:0] cmp_a_ff;
    reg [7:0] cmp_b_ff;
    reg [7:0] ctrl_a_ff;
    reg [7:0] ctrl_b_ff;
    reg [7:0] count_rd_ff;
    reg [2:0] sleep_ff;
    reg osc_s1_ff;
    reg osc_s2_ff;
    reg osc_prev_ff;
    reg [2:0] flag_raw_ff;
    reg [2:0] flag_s1_ff;
    reg [2:0] flag_s2_ff;
    reg [2:0] flag_s3_ff;
    reg [2:0] flags_ff;
    reg wake_pend_ff;
    reg rearm_ff;
    reg [2:0] halt_cnt_ff;
    wire async_mode = status_ff[`ATRS_BIT_ASYNC];
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire [4:0] wsel;
    wire [4:0] busy;
    wire [4:0] load;
    wire [39:0] hold;
    wire osc_rise = osc_s2_ff && !osc_prev_ff;
    wire tick = async_mode ? osc_rise : 1'b1;
    wire osc_stopped = (sleep_ff == `ATRS_SLEEP_PDOWN) || (sleep_ff == `ATRS_SLEEP_STBY);
    wire timer_tick = tick && !(async_mode && osc_stopped);
    wire [7:0] nxt_count = count_ff + 8'h01;
    wire cmp_block = busy[4] | busy[3] | busy[2];
    wire match_a = timer_tick && !cmp_block && (count_ff == cmp_a_ff);
    wire match_b = timer_tick && !cmp_block && (count_ff == cmp_b_ff);
    wire ovf = timer_tick && (count_ff == 8'hff);
    wire addr_ok = (paddr == `ATRS_OFF_STATUS) || (paddr == `ATRS_OFF_COUNT) ||
                   (paddr == `ATRS_OFF_CMP_A) || (paddr == `ATRS_OFF_CMP_B) ||
                   (paddr == `ATRS_OFF_CTRL_A) || (paddr == `ATRS_OFF_CTRL_B) ||
                   (paddr == `ATRS_OFF_FLAGS) || (paddr == `ATRS_OFF_SLEEP);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wsel[4] = wr && (paddr == `ATRS_OFF_COUNT);
    assign wsel[3] = wr && (paddr == `ATRS_OFF_CMP_A);
    assign wsel[2] = wr && (paddr == `ATRS_OFF_CMP_B);
    assign wsel[1] = wr && (paddr == `ATRS_OFF_CTRL_A);
    assign wsel[0] = wr && (paddr == `ATRS_OFF_CTRL_B);
    // The crystal runs only with external clock off, and stops in deep sleep.
    assign osc_enable = async_mode && !status_ff[`ATRS_BIT_EXT_CLK] && !osc_stopped;
    assign ext_clk_buf_en = async_mode && status_ff[`ATRS_BIT_EXT_CLK];
    assign irq_wake = |flags_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_slot
            atrs_hold_slot #(.W(8)) u_slot (
                .pclk(pclk),
                .presetn(presetn),
                .wr(wsel[gi]),
                .async_mode(async_mode),
                .tick(osc_rise),
                .wdata(pwdata[7:0]),
                .hold_ff(hold[gi*8 +: 8]),
                .busy(busy[gi]),
                .load(load[gi])
            );
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
        end else begin
            osc_s1_ff <= timer_osc_in_pin;
            osc_s2_ff <= osc_s1_ff;
            osc_prev_ff <= osc_s2_ff;
        end
    end

    // Status register: select and enable bits are writable, busy bits mirror the slots.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= `ATRS_STATUS_RST;
            sleep_ff <= 3'h0;
        end else begin
            if (wr && paddr == `ATRS_OFF_STATUS) begin
                status_ff[`ATRS_BIT_EXT_CLK] <= pwdata[`ATRS_BIT_EXT_CLK];
                status_ff[`ATRS_BIT_ASYNC] <= pwdata[`ATRS_BIT_ASYNC];
            end
            status_ff[4:0] <= busy;
            status_ff[7] <= 1'b0;
            if (wr && paddr == `ATRS_OFF_SLEEP) begin
                sleep_ff <= pwdata[2:0];
            end else if (cpu_halt_ff) begin
                sleep_ff <= 3'h0;
            end
        end
    end

    // Timer-domain registers. A write in synchronous mode takes effect directly.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= `ATRS_REG_RST;
            cmp_a_ff <= `ATRS_REG_RST;
            cmp_b_ff <= `ATRS_REG_RST;
            ctrl_a_ff <= `ATRS_REG_RST;
            ctrl_b_ff <= `ATRS_REG_RST;
            cmp_a_out_ff <= 1'b0;
            cmp_b_out_ff <= 1'b0;
        end else begin
            if (!async_mode && wsel[4]) begin
                count_ff <= pwdata[7:0];
            end else if (load[4]) begin
                count_ff <= hold[39:32];
            end else if (timer_tick) begin
                count_ff <= nxt_count;
            end
            if ((!async_mode && wsel[3]) || load[3]) begin
                cmp_a_ff <= async_mode ? hold[31:24] : pwdata[7:0];
            end
            if ((!async_mode && wsel[2]) || load[2]) begin
                cmp_b_ff <= async_mode ? hold[23:16] : pwdata[7:0];
            end
            if ((!async_mode && wsel[1]) || load[1]) begin
                ctrl_a_ff <= async_mode ? hold[15:8] : pwdata[7:0];
            end
            if ((!async_mode && wsel[0]) || load[0]) begin
                ctrl_b_ff <= async_mode ? hold[7:0] : pwdata[7:0];
            end
            // Outputs toggle on the timer tick itself, with no processor resync.
            if (match_a) begin
                cmp_a_out_ff <= !cmp_a_out_ff;
            end
            if (match_b) begin
                cmp_b_out_ff <= !cmp_b_out_ff;
            end
        end
    end

    // In async mode the count read copy refreshes only on an oscillator edge, so after a
    // power-save wake it shows the count sampled at the wake edge until the next edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_rd_ff <= `ATRS_REG_RST;
        end else if (!async_mode || osc_rise) begin
            count_rd_ff <= count_ff;
        end
    end

    // Flags raised in the timer domain wait for the next timer tick, then pass
    // three processor stages; only the last two feed the edge detect, so the
    // first stage is never read by anything but the second.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_raw_ff <= 3'h0;
            flag_s1_ff <= 3'h0;
            flag_s2_ff <= 3'h0;
            flag_s3_ff <= 3'h0;
            flags_ff <= 3'h0;
        end else begin
            if (timer_tick) begin
                flag_raw_ff <= {match_b, match_a, ovf};
            end
            flag_s1_ff <= flag_raw_ff;
            flag_s2_ff <= flag_s1_ff;
            flag_s3_ff <= flag_s2_ff;
            if (wr && paddr == `ATRS_OFF_FLAGS) begin
                flags_ff <= (flags_ff & ~pwdata[2:0]) | (flag_s3_ff & ~flag_s2_ff);
            end else begin
                flags_ff <= flags_ff | (flag_s3_ff & ~flag_s2_ff);
            end
        end
    end

    // Wake: a flag seen in power-save or noise sleep starts wake on the next
    // timer tick, then the processor is halted for four cycles. The interrupt
    // logic rearms only after one more oscillator edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_pend_ff <= 1'b0;
            rearm_ff <= 1'b1;
            halt_cnt_ff <= 3'h0;
            cpu_halt_ff <= 1'b0;
        end else begin
            if (rearm_ff && (|flags_ff) &&
                (sleep_ff == `ATRS_SLEEP_PSAVE || sleep_ff == `ATRS_SLEEP_NOISE)) begin
                wake_pend_ff <= 1'b1;
                rearm_ff <= 1'b0;
            end else if (!rearm_ff && !wake_pend_ff && tick) begin
                rearm_ff <= 1'b1;
            end
            if (wake_pend_ff && tick) begin
                wake_pend_ff <= 1'b0;
                halt_cnt_ff <= `ATRS_WAKE_HALT_CYC;
                cpu_halt_ff <= 1'b1;
            end else if (halt_cnt_ff > 3'h1) begin
                halt_cnt_ff <= halt_cnt_ff - 3'h1;
            end else begin
                halt_cnt_ff <= 3'h0;
                cpu_halt_ff <= 1'b0;
            end
        end
    end

    always @* begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                `ATRS_OFF_STATUS: prdata[7:0] = status_ff;
                `ATRS_OFF_COUNT: prdata[7:0] = async_mode ? count_rd_ff : count_ff;
                `ATRS_OFF_CMP_A: prdata[7:0] = hold[31:24];
                `ATRS_OFF_CMP_B: prdata[7:0] = hold[23:16];
                `ATRS_OFF_CTRL_A: prdata[7:0] = hold[15:8];
                `ATRS_OFF_CTRL_B: prdata[7:0] = hold[7:0];
                `ATRS_OFF_FLAGS: prdata[2:0] = flags_ff;
                `ATRS_OFF_SLEEP: prdata[2:0] = sleep_ff;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // atrs_top

/* File: atrs_top_assertions.sv */
// Purpose: Port-level checker for the asynchronous timer register block.
// Assumes: Offsets and sleep codes from the shared constants header.
// Notes: Sees only top-level ports; bound to every atrs_top instance.
`include "atrs_consts.vh"
module atrs_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic timer_osc_in_pin,
    input logic osc_enable,
    input logic ext_clk_buf_en,
    input logic cmp_a_out_ff,
    input logic cmp_b_out_ff,
    input logic irq_wake,
    input logic cpu_halt_ff
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable;
    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    property p_err; pslverr == (acc && (paddr > 12'h01c || paddr[1:0] != 2'b00)); endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_idle; !(acc && !pwrite) |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("prdata not zero outside read");
    property p_hi; prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("prdata upper bits set");
    property p_ext;
        acc && pwrite && paddr == `ATRS_OFF_STATUS && pwdata[6:5] == 2'b11
            |=> ext_clk_buf_en && !osc_enable;
    endproperty
    a_ext: assert property (p_ext) else $error("external clock enable wrong");
    property p_sync;
        acc && pwrite && paddr == `ATRS_OFF_STATUS && !pwdata[5] |=> !osc_enable && !ext_clk_buf_en;
    endproperty
    a_sync: assert property (p_sync) else $error("oscillator on in sync mode");
    property p_halt; $rose(cpu_halt_ff) |-> cpu_halt_ff [*4] ##1 !cpu_halt_ff; endproperty
    a_halt: assert property (p_halt) else $error("halt length wrong");
    property p_pd;
        acc && pwrite && paddr == `ATRS_OFF_SLEEP && pwdata[2:0] == `ATRS_SLEEP_PDOWN
            |=> !osc_enable;
    endproperty
    a_pd: assert property (p_pd) else $error("oscillator runs in power-down");
    property p_b7; acc && !pwrite && paddr == `ATRS_OFF_STATUS |-> !prdata[7]; endproperty
    a_b7: assert property (p_b7) else $error("status bit 7 set");
    c_halt: cover property ($rose(cpu_halt_ff));
    c_err: cover property (pslverr);
    c_ext: cover property ($rose(ext_clk_buf_en));
endmodule // atrs_chk
bind atrs_top atrs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_osc_in_pin(timer_osc_in_pin), .osc_enable(osc_enable),
    .ext_clk_buf_en(ext_clk_buf_en), .cmp_a_out_ff(cmp_a_out_ff),
    .cmp_b_out_ff(cmp_b_out_ff), .irq_wake(irq_wake), .cpu_halt_ff(cpu_halt_ff));

/* File: async_timer_register_sync_tb_top.sv */
// Purpose: Self-checking bench for the asynchronous timer register block.
// Assumes: Oscillator pin driven by the bench at one sixteenth of pclk.
// Notes: Sync-mode cases run from a table; async transfer cases follow by hand.
`include "atrs_consts.vh"
module async_timer_register_sync_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} atrs_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc = 0, e, q, qb;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, r;
    logic [7:0] c0;
    wire [31:0] prdata;
    wire pready, pslverr, osc_enable, ext_clk_buf_en, cmp_a_out_ff, cmp_b_out_ff, irq_wake, halt;
    int n_fail = 0, n_checks = 0, nh = 0;
    atrs_row_t rows [12] = '{'{1, `ATRS_OFF_CMP_A, 8'h5a, 0, 0}, '{0, `ATRS_OFF_CMP_A, 0, 8'h5a, 0},
        '{1, `ATRS_OFF_CMP_B, 8'ha5, 0, 0}, '{0, `ATRS_OFF_CMP_B, 0, 8'ha5, 0},
        '{1, `ATRS_OFF_CTRL_A, 8'h0f, 0, 0}, '{0, `ATRS_OFF_CTRL_A, 0, 8'h0f, 0},
        '{1, `ATRS_OFF_CTRL_B, 8'h07, 0, 0}, '{0, `ATRS_OFF_CTRL_B, 0, 8'h07, 0},
        '{1, `ATRS_OFF_STATUS, 8'h40, 0, 0}, '{0, `ATRS_OFF_STATUS, 0, 8'h40, 0},
        '{1, 12'h020, 8'h11, 0, 1}, '{0, 12'h020, 0, 8'h00, 1}};
    atrs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_osc_in_pin(osc), .osc_enable(osc_enable),
        .ext_clk_buf_en(ext_clk_buf_en), .cmp_a_out_ff(cmp_a_out_ff),
        .cmp_b_out_ff(cmp_b_out_ff), .irq_wake(irq_wake), .cpu_halt_ff(halt));
    always #5 pclk = ~pclk;
    task final_report;
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            $display("MISMATCH t=%0t pready timeout", $time);
            final_report;
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d); apb(1, a, {24'h0, d}); endtask
    task rd(input logic [11:0] a, input logic [7:0] x); apb(0, a, 0); chk(r, {24'h0, x}); endtask
    // One oscillator period of 16 pclk, well above the four-to-one ratio, then settle time.
    task tick;
        repeat (8) @(posedge pclk);
        osc <= 1;
        repeat (8) @(posedge pclk);
        osc <= 0;
        repeat (8) @(posedge pclk);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        foreach (rows[k]) begin
            apb(rows[k].w, rows[k].a, {24'h0, rows[k].d});
            if (!rows[k].w) chk(r, {24'h0, rows[k].x});
            chk({31'h0, e}, {31'h0, rows[k].e});
        end
        wr(`ATRS_OFF_STATUS, 8'h00);
        rd(`ATRS_OFF_STATUS, 8'h00);
        wr(`ATRS_OFF_STATUS, 8'h20);
        wr(`ATRS_OFF_FLAGS, 8'h07);
        chk(osc_enable, 1);
        wr(`ATRS_OFF_CMP_A, 8'h33);
        rd(`ATRS_OFF_CMP_A, 8'h33);
        rd(`ATRS_OFF_STATUS, 8'h28);
        tick;
        rd(`ATRS_OFF_STATUS, 8'h28);
        wr(`ATRS_OFF_CMP_B, 8'h44);
        tick;
        rd(`ATRS_OFF_STATUS, 8'h24);
        tick;
        rd(`ATRS_OFF_STATUS, 8'h20);
        apb(0, `ATRS_OFF_COUNT, 0);
        c0 = r[7:0];
        repeat (3) tick;
        rd(`ATRS_OFF_COUNT, c0 + 8'h03);
        q = cmp_a_out_ff;
        qb = cmp_b_out_ff;
        wr(`ATRS_OFF_CMP_A, c0 + 8'h07);
        wr(`ATRS_OFF_CMP_B, c0 + 8'h08);
        repeat (6) tick;
        chk(cmp_a_out_ff, {31'h0, ~q});
        chk(cmp_b_out_ff, {31'h0, ~qb});
        apb(0, `ATRS_OFF_FLAGS, 0);
        chk(r & 32'h6, 32'h6);
        chk(irq_wake, 1);
        wr(`ATRS_OFF_SLEEP, `ATRS_SLEEP_PSAVE);
        @(posedge pclk);
        chk(osc_enable, 1);
        repeat (8) @(posedge pclk);
        osc <= 1;
        repeat (16) begin
            @(posedge pclk);
            if (halt === 1'b1) nh++;
        end
        osc <= 0;
        repeat (8) @(posedge pclk);
        chk(nh, `ATRS_WAKE_HALT_CYC);
        rd(`ATRS_OFF_SLEEP, 8'h00);
        wr(`ATRS_OFF_FLAGS, 8'h07);
        repeat (2) @(posedge pclk);
        chk(irq_wake, 0);
        wr(`ATRS_OFF_SLEEP, `ATRS_SLEEP_PDOWN);
        @(posedge pclk);
        chk(osc_enable, 0);
        wr(`ATRS_OFF_SLEEP, 8'h00);
        wr(`ATRS_OFF_STATUS, 8'h60);
        @(posedge pclk);
        chk({ext_clk_buf_en, osc_enable}, 2'b10);
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rd(`ATRS_OFF_STATUS, 8'h00);
        chk(ext_clk_buf_en, 0);
        final_report;
    end
endmodule // async_timer_register_sync_tb_top
